/* inc/ucrf_params.svh */
// Constants for the transceiver core: field positions, resets, timing
`ifndef UCRF_PARAMS_SVH
`define UCRF_PARAMS_SVH

// ------------------------------------------------------------
// Register field positions
// ------------------------------------------------------------
`define UCRF_IER_ENH_BIT 5
`define UCRF_MCR_SOFT_RST_BIT 2

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define UCRF_DIVISOR_RST 16'h0001
`define UCRF_IER_RST 8'h00
`define UCRF_MCR_RST 8'h00
`define UCRF_LCR_RST 8'h03
`define UCRF_SPR_RST 8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define UCRF_OVERSAMPLE 16
`define UCRF_MID_SAMPLE 8
`define UCRF_DIV_W 16

`endif

/* inc/ucrf_pkg.sv */
// Types shared by the transceiver core files
package ucrf_pkg;

  // Frame format carried from the configuration to the shifters
  typedef struct packed {
    logic [1:0] word_len;
    logic two_stop;
    logic parity_en;
    logic parity_even;
  } ucrf_frame_t;

  // Modem status sampled from the pins, active high after inversion
  typedef struct packed {
    logic cts;
    logic dsr;
    logic cd;
    logic ri;
  } ucrf_modem_t;

  // Receiver result
  typedef struct packed {
    logic [7:0] data;
    logic parity_err;
    logic framing_err;
  } ucrf_rx_t;

  typedef enum logic [2:0] {
    UCRF_IDLE = 3'b000,
    UCRF_START = 3'b001,
    UCRF_DATA = 3'b010,
    UCRF_PARITY = 3'b011,
    UCRF_STOP = 3'b100
  } ucrf_state_t;

endpackage

/* design/ucrf_baud_gen.sv */
// Divider that makes the sixteen-times sampling tick
`include "ucrf_params.svh"
module ucrf_baud_gen
  import ucrf_pkg::*;
#(
  parameter int DIV_W = `UCRF_DIV_W
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Divisor, zero treated as one
  input wire logic [DIV_W-1:0] divisor,
  // One-cycle sampling tick
  output logic tick_q
);

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic tick_d;

  // ----------------------------------------------------------
  // Divide the core clock by the divisor
  // ----------------------------------------------------------
  always_comb
  begin
    tick_d = 1'b0;
    cnt_d = cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
    if (cnt_q + {{(DIV_W-1){1'b0}}, 1'b1} >= divisor)
    begin
      cnt_d = '0;
      tick_d = 1'b1;
    end
  end

  // Registered so the tick is glitch free
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

endmodule

/* design/ucrf_rx.sv */
// Receive shifter: start validation, mid-bit sampling, parity check
`include "ucrf_params.svh"
module ucrf_rx
  import ucrf_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Sampling tick and frame format
  input wire logic tick,
  input wire ucrf_frame_t frame,
  // Synchronised serial input
  input wire logic rx_in,
  // Result, strobe one cycle
  output ucrf_rx_t result_q,
  output logic done_q
);

  ucrf_state_t st_q, st_d;
  logic [3:0] ph_q, ph_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic par_q, par_d;
  logic stop2_q, stop2_d;
  ucrf_rx_t res_d;
  logic done_d;

  // ----------------------------------------------------------
  // Receive state machine; samples at phase eight of each bit
  // ----------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    ph_d = ph_q;
    bit_d = bit_q;
    sh_d = sh_q;
    par_d = par_q;
    stop2_d = stop2_q;
    res_d = result_q;
    done_d = 1'b0;
    if (tick)
    begin
      ph_d = ph_q + 4'h1;
      unique case (st_q)
        UCRF_IDLE:
        begin
          ph_d = 4'h0;
          if (!rx_in)
            st_d = UCRF_START;
        end
        UCRF_START:
          if (ph_q == 4'(`UCRF_MID_SAMPLE - 1))
          begin
            // False start is dropped before assembling a character
            ph_d = 4'h0;
            bit_d = 3'h0;
            par_d = 1'b0;
            stop2_d = 1'b0;
            st_d = rx_in ? UCRF_IDLE : UCRF_DATA;
          end
        UCRF_DATA:
          if (ph_q == 4'hF)
          begin
            sh_d = {rx_in, sh_q[7:1]};
            par_d = par_q ^ rx_in;
            bit_d = bit_q + 3'h1;
            if (bit_q == {1'b1, frame.word_len})
              st_d = frame.parity_en ? UCRF_PARITY : UCRF_STOP;
          end
        UCRF_PARITY:
          if (ph_q == 4'hF)
          begin
            par_d = par_q ^ rx_in;
            st_d = UCRF_STOP;
          end
        UCRF_STOP:
          if (ph_q == 4'hF)
          begin
            if (frame.two_stop && !stop2_q && rx_in)
              stop2_d = 1'b1;
            else
            begin
              // Short words are right-aligned in the byte
              res_d.data = sh_q >> (3'h3 - {1'b0, frame.word_len});
              res_d.parity_err = frame.parity_en &
                (par_q != !frame.parity_even);
              res_d.framing_err = !rx_in;
              done_d = 1'b1;
              st_d = UCRF_IDLE;
            end
          end
        default: st_d = UCRF_IDLE;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_q <= UCRF_IDLE;
      ph_q <= 4'h0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      par_q <= 1'b0;
      stop2_q <= 1'b0;
      result_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      par_q <= par_d;
      stop2_q <= stop2_d;
      result_q <= res_d;
      done_q <= done_d;
    end
  end

endmodule

/* design/ucrf_core.sv */
// Transceiver core: configuration, transmitter, receiver, reset output
`include "ucrf_params.svh"
module ucrf_core
  import ucrf_pkg::*;
#(
  parameter int DIV_W = `UCRF_DIV_W
)
(
  // Clock and reset; clock is the oscillator clock after its buffer
  input wire logic clock,
  input wire logic rst,
  // Configuration loads, one-cycle strobes from host logic
  input wire logic cfg_we,
  input wire logic [2:0] cfg_sel,
  input wire logic [7:0] cfg_wdata,
  // Transmit byte stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_enable,
  output logic tx_ready_q,
  // Receive byte stream
  output logic rx_valid_q,
  output ucrf_rx_t rx_result_q,
  // Serial and modem pins
  input wire logic rx_pin,
  input wire logic data_set_ready_n,
  input wire logic carrier_detect_n,
  input wire logic ring_indicator_n,
  input wire logic clear_to_send_n,
  output logic tx_pin_q,
  output logic reset_out_q,
  // Observed configuration and status
  output ucrf_modem_t modem_q,
  output logic [7:0] scratchpad_q,
  output logic [7:0] ier_q,
  output logic [7:0] mcr_q
);

  // ----------------------------------------------------------
  // Configuration selectors
  // ----------------------------------------------------------
  localparam logic [2:0] SEL_IER = 3'h1;
  localparam logic [2:0] SEL_LCR = 3'h3;
  localparam logic [2:0] SEL_MCR = 3'h4;
  localparam logic [2:0] SEL_SPR = 3'h7;
  localparam logic [2:0] SEL_DLL = 3'h0;
  localparam logic [2:0] SEL_DLM = 3'h2;

  logic [7:0] lcr_q, lcr_d;
  logic [7:0] ier_d, mcr_d, spr_d;
  logic [DIV_W-1:0] div_q, div_d;
  ucrf_frame_t frame;
  logic tick;

  // Configuration writes; hardware reset alone restores them
  always_comb
  begin
    lcr_d = lcr_q;
    ier_d = ier_q;
    mcr_d = mcr_q;
    spr_d = scratchpad_q;
    div_d = div_q;
    if (cfg_we)
    begin
      unique case (cfg_sel)
        SEL_IER: ier_d = cfg_wdata;
        SEL_LCR: lcr_d = cfg_wdata;
        SEL_MCR: mcr_d = cfg_wdata;
        SEL_SPR: spr_d = cfg_wdata;
        SEL_DLL: div_d[7:0] = cfg_wdata;
        SEL_DLM: div_d[DIV_W-1:8] = cfg_wdata[DIV_W-9:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      lcr_q <= `UCRF_LCR_RST;
      ier_q <= `UCRF_IER_RST;
      mcr_q <= `UCRF_MCR_RST;
      scratchpad_q <= `UCRF_SPR_RST;
      div_q <= DIV_W'(`UCRF_DIVISOR_RST);
    end
    else
    begin
      lcr_q <= lcr_d;
      ier_q <= ier_d;
      mcr_q <= mcr_d;
      scratchpad_q <= spr_d;
      div_q <= div_d;
    end
  end

  // Line control fields into the frame descriptor
  assign frame.word_len = lcr_q[1:0];
  assign frame.two_stop = lcr_q[2];
  assign frame.parity_en = lcr_q[3];
  assign frame.parity_even = lcr_q[4];

  // ----------------------------------------------------------
  // Reset output
  // ----------------------------------------------------------
  // Soft bit goes to the pin only; nothing inside reads it as reset
  logic reset_out_d;
  always_comb
  begin
    if (ier_q[`UCRF_IER_ENH_BIT])
      reset_out_d = mcr_q[`UCRF_MCR_SOFT_RST_BIT];
    else
      reset_out_d = 1'b0;
  end

  // Async set keeps the pin high for the whole hardware reset
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      reset_out_q <= 1'b1;
    else
      reset_out_q <= reset_out_d;
  end

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  logic [4:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_q <= 5'h1F;
      pin_s2_q <= 5'h1F;
    end
    else
    begin
      pin_s1_q <= {rx_pin, clear_to_send_n, data_set_ready_n,
                   carrier_detect_n, ring_indicator_n};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Inverted so software sees asserted as one
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      modem_q <= '0;
    else
      modem_q <= ~pin_s2_q[3:0];
  end

  // ----------------------------------------------------------
  // Baud tick and receiver
  // ----------------------------------------------------------
  ucrf_baud_gen #(.DIV_W(DIV_W)) u_baud (
    .clock(clock),
    .rst(rst),
    .divisor(div_q),
    .tick_q(tick)
  );

  ucrf_rx u_rx (
    .clock(clock),
    .rst(rst),
    .tick(tick),
    .frame(frame),
    .rx_in(pin_s2_q[4]),
    .result_q(rx_result_q),
    .done_q(rx_valid_q)
  );

  // ----------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------
  ucrf_state_t tst_q, tst_d;
  logic [3:0] tph_q, tph_d;
  logic [2:0] tbit_q, tbit_d;
  logic [7:0] tsh_q, tsh_d;
  logic tpar_q, tpar_d;
  logic tstop2_q, tstop2_d;
  logic tx_pin_d, tx_ready_d;

  // One byte is latched per frame; ready drops until the frame ends
  always_comb
  begin
    tst_d = tst_q;
    tph_d = tph_q;
    tbit_d = tbit_q;
    tsh_d = tsh_q;
    tpar_d = tpar_q;
    tstop2_d = tstop2_q;
    tx_pin_d = tx_pin_q;
    tx_ready_d = tx_ready_q;
    unique case (tst_q)
      UCRF_IDLE:
      begin
        tx_pin_d = 1'b1;
        tx_ready_d = tx_enable;
        if (tx_valid && tx_ready_q && tx_enable)
        begin
          tsh_d = tx_data;
          tpar_d = !frame.parity_even;
          tbit_d = 3'h0;
          tph_d = 4'h0;
          tstop2_d = 1'b0;
          tx_ready_d = 1'b0;
          tst_d = UCRF_START;
        end
      end
      default:
      begin
        if (tick)
        begin
          tph_d = tph_q + 4'h1;
          if (tph_q == 4'hF)
          begin
            unique case (tst_q)
              UCRF_START:
              begin
                tx_pin_d = tsh_q[0];
                tst_d = UCRF_DATA;
              end
              UCRF_DATA:
              begin
                tpar_d = tpar_q ^ tsh_q[0];
                tsh_d = {1'b0, tsh_q[7:1]};
                tbit_d = tbit_q + 3'h1;
                if (tbit_q == {1'b1, frame.word_len})
                begin
                  tst_d = frame.parity_en ? UCRF_PARITY : UCRF_STOP;
                  tx_pin_d = frame.parity_en ?
                    (tpar_q ^ tsh_q[0]) : 1'b1;
                end
                else
                  tx_pin_d = tsh_q[1];
              end
              UCRF_PARITY:
              begin
                tx_pin_d = 1'b1;
                tst_d = UCRF_STOP;
              end
              default:
              begin
                if (frame.two_stop && !tstop2_q)
                  tstop2_d = 1'b1;
                else
                  tst_d = UCRF_IDLE;
              end
            endcase
          end
          else if (tst_q == UCRF_START)
            tx_pin_d = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tst_q <= UCRF_IDLE;
      tph_q <= 4'h0;
      tbit_q <= 3'h0;
      tsh_q <= 8'h00;
      tpar_q <= 1'b0;
      tstop2_q <= 1'b0;
      tx_pin_q <= 1'b1;
      tx_ready_q <= 1'b0;
    end
    else
    begin
      tst_q <= tst_d;
      tph_q <= tph_d;
      tbit_q <= tbit_d;
      tsh_q <= tsh_d;
      tpar_q <= tpar_d;
      tstop2_q <= tstop2_d;
      tx_pin_q <= tx_pin_d;
      tx_ready_q <= tx_ready_d;
    end
  end

endmodule

/* verification/ucrf_core_asserts.sv */
// Checker watching the transceiver core ports
`include "ucrf_params.svh"
module ucrf_core_asserts
  import ucrf_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Host side
  input wire logic cfg_we,
  input wire logic [2:0] cfg_sel,
  input wire logic [7:0] cfg_wdata,
  input wire logic tx_valid,
  input wire logic tx_enable,
  input wire logic tx_ready_q,
  // Pins
  input wire logic data_set_ready_n,
  input wire logic carrier_detect_n,
  input wire logic ring_indicator_n,
  input wire logic clear_to_send_n,
  input wire logic tx_pin_q,
  input wire logic reset_out_q,
  // Observed state
  input wire ucrf_modem_t modem_q,
  input wire logic [7:0] scratchpad_q,
  input wire logic [7:0] ier_q,
  input wire logic [7:0] mcr_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bench never programs a divisor above three
  localparam int START_MAX = 64;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Byte taken, then the line drops for the start bit
  sequence s_take;
    tx_valid && tx_ready_q && tx_enable;
  endsequence
  sequence s_start;
    !tx_ready_q ##[0:START_MAX] !tx_pin_q;
  endsequence
  sequence s_soft;
    ier_q[`UCRF_IER_ENH_BIT] && mcr_q[`UCRF_MCR_SOFT_RST_BIT];
  endsequence

  AST_RELEASE_IDLE: assert property ($fell(rst) |-> tx_pin_q && reset_out_q)
    else $error("line or reset output low in reset");
  AST_ENH_OFF: assert property (!ier_q[`UCRF_IER_ENH_BIT] [*2] |-> !reset_out_q)
    else $error("reset output high without enhanced mode");
  AST_ENH_ON: assert property (s_soft [*2] |-> reset_out_q)
    else $error("soft reset not on output");
  AST_SOFT_ONLY: assert property ((ier_q[`UCRF_IER_ENH_BIT]
    && !mcr_q[`UCRF_MCR_SOFT_RST_BIT]) [*2] |-> !reset_out_q)
    else $error("reset output high with soft bit clear");
  AST_SPR_WRITE: assert property (cfg_we && cfg_sel == 3'h7 |=> scratchpad_q == $past(cfg_wdata))
    else $error("scratchpad lost write");
  AST_SPR_HOLD: assert property (!(cfg_we && cfg_sel == 3'h7) |=> $stable(scratchpad_q))
    else $error("scratchpad changed");
  AST_IDLE_HIGH: assert property (tx_ready_q |-> tx_pin_q)
    else $error("line low while idle");
  AST_START_BIT: assert property (s_take |=> s_start)
    else $error("start bit missing");
  AST_MODEM: assert property ($stable({clear_to_send_n, data_set_ready_n,
    carrier_detect_n, ring_indicator_n}) [*5] |-> modem_q == ~{clear_to_send_n,
    data_set_ready_n, carrier_detect_n, ring_indicator_n})
    else $error("modem status wrong");
endmodule

/* verification/ucrf_peer.sv */
// Serial peer: decodes the core output line and sends frames to it
module ucrf_peer
  import ucrf_pkg::*;
(
  // Clock and line format
  input wire logic clock,
  input wire ucrf_frame_t frame,
  input wire logic [31:0] bit_clks,
  // Serial lines
  input wire logic line_in,
  output logic line_out,
  // Decoded character, one-cycle strobe
  output logic got,
  output ucrf_rx_t got_char
);
  timeunit 1ns;
  timeprecision 1ps;
  logic p;
  initial
  begin
    line_out = 1'b1;
    got = 1'b0;
    got_char = '0;
  end

  // Decoder samples mid-bit, so a short first tick is harmless
  always
  begin
    @(negedge line_in);
    repeat (bit_clks / 2) @(posedge clock);
    got_char = '0;
    got_char.framing_err = line_in;
    p = !frame.parity_even;
    for (int i = 0; i < 5 + frame.word_len; i++)
    begin
      repeat (bit_clks) @(posedge clock);
      got_char.data[i] = line_in;
      p ^= line_in;
    end
    if (frame.parity_en)
    begin
      repeat (bit_clks) @(posedge clock);
      got_char.parity_err = p ^ line_in;
    end
    for (int i = 0; i <= frame.two_stop; i++)
    begin
      repeat (bit_clks) @(posedge clock);
      got_char.framing_err |= !line_in;
    end
    got <= 1'b1;
    @(posedge clock);
    got <= 1'b0;
  end

  // One frame to the core; bad parity or stop only when asked
  task automatic send(input logic [7:0] d, input logic bp, input logic bs);
    logic q;
    q = !frame.parity_even;
    line_out <= 1'b0;
    for (int i = 0; i < 5 + frame.word_len; i++)
    begin
      repeat (bit_clks) @(posedge clock);
      line_out <= d[i];
      q ^= d[i];
    end
    if (frame.parity_en)
    begin
      repeat (bit_clks) @(posedge clock);
      line_out <= q ^ bp;
    end
    repeat (bit_clks) @(posedge clock);
    line_out <= !bs;
    repeat (bit_clks) @(posedge clock);
    line_out <= 1'b1;
    repeat (bit_clks) @(posedge clock);
  endtask
endmodule

/* verification/ucrf_core_tb.sv */
// Self-checking bench for the transceiver core
module ucrf_core_tb
  import ucrf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst, cfg_we, tx_valid, tx_enable, rx_pin, got;
  logic tx_ready_q, rx_valid_q, tx_pin_q, reset_out_q;
  logic [2:0] cfg_sel;
  logic [7:0] cfg_wdata, tx_data, scratchpad_q, ier_q, mcr_q;
  logic [3:0] modem_n;
  logic [31:0] seed = 32'hF15D;
  ucrf_rx_t rx_result_q, got_char;
  ucrf_rx_t tx_q[$], rx_q[$];
  ucrf_modem_t modem_q;
  ucrf_frame_t frame;
  int bit_clks, error_cnt, check_count;

  ucrf_core ucrf_core_inst (
    .clock(clock), .rst(rst), .cfg_we(cfg_we), .cfg_sel(cfg_sel),
    .cfg_wdata(cfg_wdata), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_enable(tx_enable), .tx_ready_q(tx_ready_q),
    .rx_valid_q(rx_valid_q), .rx_result_q(rx_result_q), .rx_pin(rx_pin),
    .data_set_ready_n(modem_n[2]), .carrier_detect_n(modem_n[1]),
    .ring_indicator_n(modem_n[0]), .clear_to_send_n(modem_n[3]),
    .tx_pin_q(tx_pin_q), .reset_out_q(reset_out_q), .modem_q(modem_q),
    .scratchpad_q(scratchpad_q), .ier_q(ier_q), .mcr_q(mcr_q)
  );
  ucrf_peer ucrf_peer_inst (
    .clock(clock), .frame(frame), .bit_clks(bit_clks), .line_in(tx_pin_q),
    .line_out(rx_pin), .got(got), .got_char(got_char)
  );

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Short words arrive right-aligned
  function automatic logic [7:0] mask(input logic [7:0] d);
    return d & (8'hFF >> (3 - frame.word_len));
  endfunction

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_char(input ucrf_rx_t g, input ucrf_rx_t e);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t char %h expected %h", $time, g, e);
    end
  endtask

  task automatic cfg(input logic [2:0] s, input logic [7:0] d);
    cfg_we <= 1'b1;
    cfg_sel <= s;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_we <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  // Leaves valid high so back-to-back bytes need no gap
  // Ready is looked at mid-cycle, away from the edge that moves it
  task automatic tx(input logic [7:0] d);
    int n;
    tx_q.push_back('{mask(d), 1'b0, 1'b0});
    tx_valid <= 1'b1;
    tx_data <= d;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (tx_ready_q !== 1'b1 && n < 5000);
    @(posedge clock);
  endtask

  task automatic rx_send(input logic [7:0] d, input logic bp, input logic bs);
    rx_q.push_back('{mask(d), bp & frame.parity_en, bs});
    ucrf_peer_inst.send(d, bp, bs);
  endtask

  // Let the line settle before the format changes
  task automatic drain();
    for (int n = 0; n < 2000 && tx_q.size() + rx_q.size() > 0; n++)
      @(posedge clock);
    repeat (2 * bit_clks) @(posedge clock);
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Result watcher: oldest note against each character that appears
  always @(posedge clock)
  begin
    if (got === 1'b1)
      cmp_char(got_char, tx_q.pop_front());
    if (rx_valid_q === 1'b1)
      cmp_char(rx_result_q, rx_q.pop_front());
  end

  // Watchdog: the run needs about 22000 cycles
  initial
  begin
    #320000;
    error_cnt++;
    $display("[FAIL] %0t run hung", $time);
    conclude();
  end

  initial
  begin
    logic [31:0] r;
    rst <= 1'b1;
    cfg_we <= 1'b0;
    cfg_sel <= 3'h0;
    cfg_wdata <= 8'h00;
    tx_valid <= 1'b0;
    tx_data <= 8'h00;
    tx_enable <= 1'b1;
    modem_n <= 4'hF;
    frame = '{2'h3, 1'b0, 1'b0, 1'b0};
    bit_clks = 16;
    repeat (2) @(posedge clock);
    cmp8({4'h0, tx_pin_q, reset_out_q, tx_ready_q, rx_valid_q}, 8'h0C);
    @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    cmp8(ier_q | mcr_q | scratchpad_q, 8'h00);
    repeat (6)
    begin
      r = rnd();
      modem_n <= r[3:0];
      repeat (5) @(posedge clock);
      cmp8({4'h0, modem_q}, {4'h0, ~modem_n});
    end
    cfg(3'h7, r[11:4]);
    cmp8(scratchpad_q, r[11:4]);
    cfg(3'h4, 8'h04);
    cmp8({7'h0, reset_out_q}, 8'h00);
    cfg(3'h1, 8'h20);
    cmp8({7'h0, reset_out_q}, 8'h01);
    cmp8(scratchpad_q, r[11:4]);
    // Disabled transmitter ignores a waiting byte
    tx_enable <= 1'b0;
    tx_valid <= 1'b1;
    repeat (2) @(posedge clock);
    repeat (20)
    begin
      @(posedge clock);
      cmp8({6'h0, tx_pin_q, tx_ready_q}, 8'h02);
    end
    tx_enable <= 1'b1;
    tx(r[19:12]);
    tx_valid <= 1'b0;
    drain();
    // Every line format both ways, soft reset still asserted
    for (int f = 0; f < 32; f++)
    begin
      if (f == 16)
      begin
        cfg(3'h0, 8'h03);
        bit_clks = 48;
      end
      cfg(3'h3, 8'(f));
      frame = '{f[1:0], f[2], f[3], f[4]};
      r = rnd();
      fork
        begin
          tx(r[7:0]);
          tx(r[15:8]);
        end
        rx_send(r[23:16], r[24], r[25] & r[26]);
      join
      tx_valid <= 1'b0;
      drain();
    end
    cmp8({7'h0, reset_out_q}, 8'h01);
    cfg(3'h4, 8'h00);
    cmp8({7'h0, reset_out_q}, 8'h00);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    cmp8(ier_q | mcr_q | scratchpad_q, 8'h00);
    frame = '{2'h3, 1'b0, 1'b0, 1'b0};
    bit_clks = 16;
    fork
      tx(8'hA5);
      rx_send(8'h3C, 1'b0, 1'b0);
    join
    tx_valid <= 1'b0;
    drain();
    cmp8(8'(tx_q.size() + rx_q.size()), 8'h00);
    conclude();
  end
endmodule

bind ucrf_core ucrf_core_asserts ucrf_core_asserts_inst (
  .clock(clock), .rst(rst), .cfg_we(cfg_we), .cfg_sel(cfg_sel),
  .cfg_wdata(cfg_wdata), .tx_valid(tx_valid), .tx_enable(tx_enable),
  .tx_ready_q(tx_ready_q), .data_set_ready_n(data_set_ready_n),
  .carrier_detect_n(carrier_detect_n), .ring_indicator_n(ring_indicator_n),
  .clear_to_send_n(clear_to_send_n), .tx_pin_q(tx_pin_q),
  .reset_out_q(reset_out_q), .modem_q(modem_q),
  .scratchpad_q(scratchpad_q), .ier_q(ier_q), .mcr_q(mcr_q)
);
